// >>> include/phy_rst_defs.svh
// What this block does
// - After pin rises, first five exit steps finish within 640 ns
// - Management port accepts transactions once those exit steps are done
// - Reset completes only when transmit and receive clocks become available
// - Power-on reset holds about 20 us then exits like hardware reset
// - Hardware reset pin is ignored during power-on reset
// - Writing one to control bit 15 gives exactly two cycles of reset
// - Software reset does not enter power-down
// - Reset completion loads register defaults, clearing the software reset bit
// - Software reset exit keeps management address, no re-latch from pins
// - Software reset bit never set during power-on reset, nor after the first cycle of hardware reset
// - Power-down whenever reset pin low or control bit 11 set
// - Power-down zeroes MAC outputs and tri-states both twisted-pair outputs
// - Power-down by bit 11 keeps registers except latching status bits
// - Extended control 2 bit 0 disables 100M modules in 10M mode
// - Extended control 2 bit 1 disables 10M modules in 100M mode
// - Reset entry isolates MAC, tri-states line, inits, clears latches; pin and power-on resets also power down
// - Hardware or power-on exit latches management address from pins
`ifndef PHY_RST_DEFS_SVH
`define PHY_RST_DEFS_SVH

`define CLK_MHZ        20
`define EXIT_TIME_NS   640
`define EXIT_CYC       ((`EXIT_TIME_NS * `CLK_MHZ) / 1000)
`define POR_TIME_NS    20000
`define POR_CYC        ((`POR_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CLK_WAIT_MS    53
`define CLK_WAIT_DEF   (`CLK_WAIT_MS * `CLK_MHZ * 1000)
`define HW_LOW_MIN     3'h5
`define SW_HOLD_CYC    2

`define REG_CTRL       5'h00
`define REG_EXT1       5'h10
`define REG_STAT       5'h11
`define REG_EXT2       5'h13

`define CTRL_SWRST     15
`define CTRL_PD        11
`define EXT1_ADDR_LO   6
`define EXT1_ADDR_HI   10
`define EXT2_DIS100    0
`define EXT2_DIS10     1
`define CTRL_DEF       16'h0000
`define EXT2_DEF       2'h0
`define LL_DEF         1'b1
`define LH_DEF         1'b0
`define LMX_DEF        4'h0

`endif

// >>> include/phy_rst_pkg.sv
`include "phy_rst_defs.svh"
package phy_rst_pkg;

  typedef enum logic [5:0] {
    ST_POR  = 6'h01,
    ST_HW   = 6'h02,
    ST_SW   = 6'h04,
    ST_EXIT = 6'h08,
    ST_CLKW = 6'h10,
    ST_RUN  = 6'h20
  } state_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic mac_in_isolate;
    logic mac_out_low;
    logic twisted_pair_tx_positive_oe;
    logic twisted_pair_tx_negative_oe;
  } pin_ctl_type;

endpackage : phy_rst_pkg

// >>> src/hw_reset_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_rst_defs.svh"
module hw_reset_filter (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hw_reset_low_pin,
  output logic      pin_low,
  output logic      reset_req
);
  logic       meta_ff;
  logic       sync_ff;
  logic [2:0] low_cnt_ff;
  logic [2:0] nxt_low_cnt;

  assign nxt_low_cnt = sync_ff ? 3'h0 :
                       (low_cnt_ff == `HW_LOW_MIN) ? low_cnt_ff : low_cnt_ff + 3'h1;
  assign pin_low     = ~sync_ff;
  assign reset_req   = (low_cnt_ff == `HW_LOW_MIN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff    <= 1'b1;
      sync_ff    <= 1'b1;
      low_cnt_ff <= 3'h0;
    end else begin
      meta_ff    <= hw_reset_low_pin;
      sync_ff    <= meta_ff;
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  property p_req_needs_five;
    @(posedge clk) disable iff (rst)
    $rose(reset_req) |-> $past(pin_low, 1) && $past(pin_low, 2) && $past(pin_low, 3)
                         && $past(pin_low, 4) && $past(pin_low, 5);
  endproperty
  a_req_needs_five: assert property (p_req_needs_five)
    else $error("reset request without five low cycles");

endmodule : hw_reset_filter
`default_nettype wire

// >>> src/phy_reset_powerdown_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_rst_defs.svh"
module phy_reset_powerdown_ctrl #(
  parameter int unsigned CLK_WAIT_CYC = `CLK_WAIT_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     hw_reset_low_pin,
  input  wire logic [4:0]               addr_strap_pins,
  input  wire phy_rst_pkg::bus_req_type bus_req,
  output logic [15:0]                   rd_data,
  input  wire logic                     speed_100,
  input  wire logic                     link_up,
  input  wire logic                     fault_event,
  input  wire logic [3:0]               err_level,
  output phy_rst_pkg::pin_ctl_type      pin_ctl,
  output logic                          mgmt_ready,
  output logic                          clocks_valid,
  output logic                          power_down,
  output logic                          mod100_en,
  output logic                          mod10_en,
  output logic                          sm_init
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int EXIT_N = `EXIT_CYC;
  localparam int POR_N  = `POR_CYC;

  phy_rst_pkg::state_type state_ff;
  phy_rst_pkg::state_type nxt_state;
  logic [20:0] cnt_ff;
  logic [20:0] nxt_cnt;
  logic        from_sw_ff;
  logic [15:0] ctrl_ff;
  logic [4:0]  phy_addr_ff;
  logic [1:0]  ext2_ff;
  logic        ll_ff;
  logic        lh_ff;
  logic [3:0]  lmx_ff;
  logic        pd_bit_prev_ff;
  logic [15:0] rd_data_ff;
  logic        pin_low;
  logic        hw_req;

  hw_reset_filter u_filter (
    .clk              (clk),
    .rst              (rst),
    .hw_reset_low_pin (hw_reset_low_pin),
    .pin_low          (pin_low),
    .reset_req        (hw_req)
  );

  // ****************************************
  // Decode
  // ****************************************
  wire in_por   = (state_ff == phy_rst_pkg::ST_POR);
  wire in_hw    = (state_ff == phy_rst_pkg::ST_HW);
  wire in_sw    = (state_ff == phy_rst_pkg::ST_SW);
  wire in_exit  = (state_ff == phy_rst_pkg::ST_EXIT);
  wire in_clkw  = (state_ff == phy_rst_pkg::ST_CLKW);
  wire in_run   = (state_ff == phy_rst_pkg::ST_RUN);
  wire in_hold  = in_por | in_hw | in_sw;
  wire hw_take  = hw_req & ~in_por & ~in_hw;
  wire wr_ok    = bus_req.wr & mgmt_ready;
  wire wr_ctrl  = wr_ok & (bus_req.addr == `REG_CTRL);
  wire wr_ext1  = wr_ok & (bus_req.addr == `REG_EXT1);
  wire wr_ext2  = wr_ok & (bus_req.addr == `REG_EXT2);
  wire rd_stat  = bus_req.rd & (bus_req.addr == `REG_STAT);
  wire sw_start = wr_ctrl & bus_req.wdata[`CTRL_SWRST];
  wire pd_bit   = ctrl_ff[`CTRL_PD];
  wire pd_rise  = pd_bit & ~pd_bit_prev_ff;
  wire lat_clr  = in_hold | pd_rise;
  wire por_done = (cnt_ff == 21'(`POR_CYC - 1));
  wire sw_done  = (cnt_ff == 21'(`SW_HOLD_CYC - 1));
  wire clk_done = (cnt_ff == 21'(CLK_WAIT_CYC - 1));

  assign mgmt_ready   = in_clkw | in_run;
  assign clocks_valid = in_run;
  assign power_down   = (in_hold & ~in_sw) | (pin_low & ~in_por) | pd_bit;
  wire drive_ok       = mgmt_ready & ~power_down;
  assign pin_ctl.mac_in_isolate              = ~drive_ok;
  assign pin_ctl.mac_out_low                 = ~drive_ok;
  assign pin_ctl.twisted_pair_tx_positive_oe = drive_ok;
  assign pin_ctl.twisted_pair_tx_negative_oe = drive_ok;
  assign sm_init      = in_hold | in_exit;
  assign mod100_en    = drive_ok & ~(~speed_100 & ext2_ff[`EXT2_DIS100]);
  assign mod10_en     = drive_ok & ~(speed_100 & ext2_ff[`EXT2_DIS10]);
  assign rd_data      = rd_data_ff;

  wire [15:0] stat_word = {6'h00, lmx_ff, lh_ff, ll_ff, power_down, clocks_valid,
                           mgmt_ready, from_sw_ff};
  wire [15:0] ext1_word = {5'h00, phy_addr_ff, 6'h00};
  wire [15:0] rd_mux    = (bus_req.addr == `REG_CTRL) ? ctrl_ff :
                          (bus_req.addr == `REG_EXT1) ? ext1_word :
                          (bus_req.addr == `REG_STAT) ? stat_word :
                          (bus_req.addr == `REG_EXT2) ? {14'h0000, ext2_ff} : 16'h0000;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      phy_rst_pkg::ST_POR:  if (por_done) nxt_state = phy_rst_pkg::ST_EXIT;
      phy_rst_pkg::ST_HW:   if (!pin_low) nxt_state = phy_rst_pkg::ST_EXIT;
      phy_rst_pkg::ST_SW:   if (hw_take) nxt_state = phy_rst_pkg::ST_HW;
                            else if (sw_done) nxt_state = phy_rst_pkg::ST_EXIT;
      phy_rst_pkg::ST_EXIT: if (hw_take) nxt_state = phy_rst_pkg::ST_HW;
                            else nxt_state = phy_rst_pkg::ST_CLKW;
      phy_rst_pkg::ST_CLKW: if (hw_take) nxt_state = phy_rst_pkg::ST_HW;
                            else if (sw_start) nxt_state = phy_rst_pkg::ST_SW;
                            else if (clk_done) nxt_state = phy_rst_pkg::ST_RUN;
      phy_rst_pkg::ST_RUN:  if (hw_take) nxt_state = phy_rst_pkg::ST_HW;
                            else if (sw_start) nxt_state = phy_rst_pkg::ST_SW;
      default:              nxt_state = phy_rst_pkg::ST_POR;
    endcase
  end

  assign nxt_cnt = (nxt_state != state_ff) ? 21'h000000 : cnt_ff + 21'h000001;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= phy_rst_pkg::ST_POR;
      cnt_ff     <= 21'h000000;
      from_sw_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      from_sw_ff <= (nxt_state == phy_rst_pkg::ST_SW) ? 1'b1 :
                    (nxt_state == phy_rst_pkg::ST_HW) ? 1'b0 : from_sw_ff;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CTRL_DEF;
      ext2_ff <= `EXT2_DEF;
    // bit held clear in pin resets
    end else if (in_por || in_hw || in_exit) begin
      ctrl_ff <= `CTRL_DEF;
      ext2_ff <= `EXT2_DEF;
    end else begin
      if (wr_ctrl) ctrl_ff <= bus_req.wdata;
      if (wr_ext2) ext2_ff <= bus_req.wdata[`EXT2_DIS10:`EXT2_DIS100];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phy_addr_ff <= 5'h00;
    end else if (in_exit && !from_sw_ff) begin
      phy_addr_ff <= addr_strap_pins;
    end else if (wr_ext1) begin
      phy_addr_ff <= bus_req.wdata[`EXT1_ADDR_HI:`EXT1_ADDR_LO];
    end
  end

  // Event beats read-clear in the same cycle
  wire       nxt_ll  = lat_clr ? `LL_DEF : ((rd_stat ? `LL_DEF : ll_ff) & link_up);
  wire       nxt_lh  = lat_clr ? `LH_DEF : ((rd_stat ? `LH_DEF : lh_ff) | fault_event);
  wire [3:0] lmx_b   = rd_stat ? `LMX_DEF : lmx_ff;
  wire [3:0] nxt_lmx = lat_clr ? `LMX_DEF : ((err_level > lmx_b) ? err_level : lmx_b);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ll_ff          <= `LL_DEF;
      lh_ff          <= `LH_DEF;
      lmx_ff         <= `LMX_DEF;
      pd_bit_prev_ff <= 1'b0;
      rd_data_ff     <= 16'h0000;
    end else begin
      ll_ff          <= nxt_ll;
      lh_ff          <= nxt_lh;
      lmx_ff         <= nxt_lmx;
      pd_bit_prev_ff <= pd_bit;
      rd_data_ff     <= bus_req.rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sw_hold;
    in_sw [*2];
  endsequence
  property p_sw_two;
    $rose(in_sw) && !hw_take |-> s_sw_hold ##1 (in_exit || in_hw);
  endproperty
  a_sw_two: assert property (p_sw_two)
    else $error("software reset hold not two cycles");

  property p_por_len;
    $fell(in_por) |-> $past(cnt_ff) == 21'(POR_N - 1) && in_exit;
  endproperty
  a_por_len: assert property (p_por_len)
    else $error("power-on hold wrong length");

  property p_exit_fast;
    in_hw && !pin_low |-> ##[1:EXIT_N] mgmt_ready;
  endproperty
  a_exit_fast: assert property (p_exit_fast)
    else $error("exit steps too slow");

  property p_por_ignores_pin;
    in_por && !por_done |=> in_por;
  endproperty
  a_por_ignores_pin: assert property (p_por_ignores_pin)
    else $error("pin disturbed power-on reset");

  property p_pd;
    (pin_low && !in_por) || pd_bit |-> power_down && !pin_ctl.twisted_pair_tx_positive_oe
                                      && pin_ctl.mac_out_low;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down not entered");

  property p_sw_no_pd;
    in_sw && !pin_low && !pd_bit |-> !power_down;
  endproperty
  a_sw_no_pd: assert property (p_sw_no_pd)
    else $error("software reset powered down");

  property p_swbit_clear;
    in_exit |=> !ctrl_ff[`CTRL_SWRST];
  endproperty
  a_swbit_clear: assert property (p_swbit_clear)
    else $error("software reset bit not cleared");

  property p_swbit_never;
    in_por || in_hw |=> !ctrl_ff[`CTRL_SWRST];
  endproperty
  a_swbit_never: assert property (p_swbit_never)
    else $error("software reset bit set in pin reset");

  property p_addr_keep;
    in_exit && from_sw_ff |=> phy_addr_ff == $past(phy_addr_ff);
  endproperty
  a_addr_keep: assert property (p_addr_keep)
    else $error("address relatched after software reset");

  property p_addr_latch;
    in_exit && !from_sw_ff |=> phy_addr_ff == $past(addr_strap_pins);
  endproperty
  a_addr_latch: assert property (p_addr_latch)
    else $error("address not latched from pins");

  property p_lat_clr;
    pd_rise |=> ll_ff == `LL_DEF && lh_ff == `LH_DEF && lmx_ff == `LMX_DEF;
  endproperty
  a_lat_clr: assert property (p_lat_clr)
    else $error("latching bits not reset on power-down");

  property p_mod100;
    drive_ok && !speed_100 |-> mod100_en == !ext2_ff[`EXT2_DIS100];
  endproperty
  a_mod100: assert property (p_mod100)
    else $error("100M module enable wrong");

  property p_mod10;
    drive_ok && speed_100 |-> mod10_en == !ext2_ff[`EXT2_DIS10];
  endproperty
  a_mod10: assert property (p_mod10)
    else $error("10M module enable wrong");

  property p_clk_done;
    $rose(clocks_valid) |-> $past(in_clkw) && $past(cnt_ff) == 21'(CLK_WAIT_CYC - 1);
  endproperty
  a_clk_done: assert property (p_clk_done)
    else $error("reset completed before clock wait");

endmodule : phy_reset_powerdown_ctrl
`default_nettype wire

// >>> tb/mgmt_station_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************
// Station and MAC side
// ************************
module mgmt_station_model (
  input  wire logic                    clk,
  input  wire logic                    clocks_valid,
  input  wire logic [15:0]             rd_data,
  output var  phy_rst_pkg::bus_req_type bus_req,
  output var  logic                    hw_reset_low_pin,
  output logic                         mac_may_use
);
  initial begin
    bus_req = '0;
    hw_reset_low_pin = 1'b1;
  end

  assign mac_may_use = clocks_valid;

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  // Data stands one cycle only, so sample just after the edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic pin(input logic v);
    @(posedge clk);
    hw_reset_low_pin <= v;
  endtask : pin
endmodule : mgmt_station_model
`default_nettype wire

// >>> tb/phy_reset_powerdown_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_rst_defs.svh"
// ************************
// Bench
// ************************
module phy_reset_powerdown_ctrl_bench;
  localparam int unsigned CW = 20;
  typedef struct packed {
    logic [1:0] ext2;
    logic       spd;
    logic       e100;
    logic       e10;
  } row_type;
  row_type rows [6] = '{'{2'h0, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b0, 1'b1},
                        '{2'h1, 1'b1, 1'b1, 1'b1}, '{2'h2, 1'b1, 1'b1, 1'b0},
                        '{2'h2, 1'b0, 1'b1, 1'b1}, '{2'h3, 1'b1, 1'b1, 1'b0}};
  logic clk, rst, speed_100, link_up, fault_event, hw_reset_low_pin;
  logic mgmt_ready, clocks_valid, power_down, mod100_en, mod10_en, sm_init;
  logic mac_may_use, pd_seen, low_seen;
  logic [4:0]  addr_strap_pins;
  logic [3:0]  err_level;
  logic [15:0] rd_data, d;
  phy_rst_pkg::bus_req_type bus_req;
  phy_rst_pkg::pin_ctl_type pin_ctl;
  int unsigned mismatches, num_checks, cyc, t0, n;

  phy_reset_powerdown_ctrl #(.CLK_WAIT_CYC(CW)) dut_u (
    .clk(clk), .rst(rst), .hw_reset_low_pin(hw_reset_low_pin),
    .addr_strap_pins(addr_strap_pins), .bus_req(bus_req), .rd_data(rd_data),
    .speed_100(speed_100), .link_up(link_up), .fault_event(fault_event),
    .err_level(err_level), .pin_ctl(pin_ctl), .mgmt_ready(mgmt_ready),
    .clocks_valid(clocks_valid), .power_down(power_down), .mod100_en(mod100_en),
    .mod10_en(mod10_en), .sm_init(sm_init));

  mgmt_station_model st_u (
    .clk(clk), .clocks_valid(clocks_valid), .rd_data(rd_data), .bus_req(bus_req),
    .hw_reset_low_pin(hw_reset_low_pin), .mac_may_use(mac_may_use));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Bounded wait on ready or clocks valid, noting power-down on the way
  task automatic wait_hi(input bit sel, input int unsigned lim, output int unsigned k);
    k = 0;
    while ((sel ? clocks_valid : mgmt_ready) !== 1'b1 && k < lim) begin
      pd_seen = pd_seen | power_down;
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_hi

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    speed_100 = 1'b0;
    link_up = 1'b1;
    fault_event = 1'b0;
    err_level = 4'h0;
    addr_strap_pins = 5'h0a;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc;
    #1;
    chk("pd_por", 16'h1, power_down);
    st_u.pin(1'b0);
    repeat (8) @(posedge clk);
    st_u.pin(1'b1);
    wait_hi(1'b0, 450, n);
    chk("por_len", 16'h1, (cyc - t0) inside {[400:404]});
    wait_hi(1'b1, 40, n);
    chk("clk_wait", 16'h1, n inside {[CW:CW + 1]});
    chk("pd_run", 16'h0, power_down);
    chk("oe_run", 16'h3, pin_ctl[1:0]);
    chk("iso_run", 16'h0, pin_ctl.mac_in_isolate);
    chk("sm_run", 16'h0, sm_init);
    chk("mac_ok", 16'h1, mac_may_use);
    st_u.rd(`REG_EXT1, d);
    chk("addr_por", 16'h0a, d[10:6]);
    $display("test power_on done");
    foreach (rows[i]) begin
      speed_100 <= rows[i].spd;
      st_u.wr(`REG_EXT2, {14'h0, rows[i].ext2});
      @(posedge clk);
      #1;
      chk("mod100", rows[i].e100, mod100_en);
      chk("mod10", rows[i].e10, mod10_en);
    end
    $display("test module_enables done");
    @(posedge clk);
    fault_event <= 1'b1;
    link_up     <= 1'b0;
    err_level   <= 4'h7;
    @(posedge clk);
    fault_event <= 1'b0;
    link_up     <= 1'b1;
    err_level   <= 4'h0;
    st_u.rd(`REG_STAT, d);
    chk("latch_set", 16'h1e, d[9:4]);
    // Set them again so the power-down clear has something to undo
    @(posedge clk);
    fault_event <= 1'b1;
    link_up     <= 1'b0;
    err_level   <= 4'h7;
    @(posedge clk);
    fault_event <= 1'b0;
    link_up     <= 1'b1;
    err_level   <= 4'h0;
    st_u.wr(`REG_CTRL, 16'h0800);
    @(posedge clk);
    #1;
    chk("pd_bit", 16'h1, power_down);
    chk("oe_pd", 16'h0, pin_ctl[1:0]);
    chk("mac_low", 16'h1, pin_ctl.mac_out_low);
    st_u.rd(`REG_STAT, d);
    chk("latches", 16'h01, d[9:4]);
    st_u.rd(`REG_EXT2, d);
    chk("ext2_kept", 16'h3, d);
    st_u.wr(`REG_CTRL, 16'h0000);
    #1;
    chk("pd_off", 16'h0, power_down);
    $display("test power_down done");
    addr_strap_pins <= 5'h15;
    st_u.wr(`REG_CTRL, 16'h8000);
    #1;
    pd_seen = 1'b0;
    wait_hi(1'b0, 10, n);
    chk("sw_len", 16'h3, n);
    chk("sw_pd", 16'h0, pd_seen);
    st_u.rd(`REG_CTRL, d);
    chk("ctrl_clr", 16'h0, d);
    st_u.rd(`REG_EXT2, d);
    chk("ext2_def", 16'h0, d);
    st_u.rd(`REG_EXT1, d);
    chk("addr_sw", 16'h0a, d[10:6]);
    $display("test soft_reset done");
    st_u.pin(1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("pd_pin", 16'h1, power_down);
    repeat (6) @(posedge clk);
    #1;
    chk("rdy_hw", 16'h0, mgmt_ready);
    chk("oe_hw", 16'h0, pin_ctl[1:0]);
    chk("iso_hw", 16'h1, pin_ctl.mac_in_isolate);
    chk("sm_hw", 16'h1, sm_init);
    st_u.rd(`REG_CTRL, d);
    chk("swbit_hw", 16'h0, d[15]);
    st_u.pin(1'b1);
    #1;
    wait_hi(1'b0, 20, n);
    chk("hw_exit", 16'h1, n <= 16);
    st_u.rd(`REG_STAT, d);
    chk("last_sw", 16'h0, d[0]);
    st_u.rd(`REG_EXT1, d);
    chk("addr_hw", 16'h15, d[10:6]);
    st_u.wr(`REG_EXT2, 16'h0002);
    st_u.rd(`REG_EXT2, d);
    chk("mgmt_ok", 16'h2, d);
    chk("mac_wait", 16'h0, mac_may_use);
    $display("test hw_reset done");
    st_u.pin(1'b0);
    repeat (2) @(posedge clk);
    st_u.pin(1'b1);
    low_seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      low_seen = low_seen | ~mgmt_ready;
    end
    chk("short_pulse", 16'h0, low_seen);
    $display("test short_pulse done");
    test_done();
  end
endmodule : phy_reset_powerdown_ctrl_bench
`default_nettype wire
